// ### clock_supervisor_map.svh
// Register offsets, field positions, reset values and counts of the clock supervisor.
`ifndef CLOCK_SUPERVISOR_MAP_SVH
`define CLOCK_SUPERVISOR_MAP_SVH

`define OSC_CONTROL_OFFSET      12'h000
`define OSC_STATUS_OFFSET       12'h004
`define OSC_FAIL_FLAG_OFFSET    12'h008
`define OSC_FAIL_IRQ_EN_OFFSET  12'h00c

`define CTRL_SOFT_PLL_BIT       7
`define CTRL_FREQ_MSB           6
`define CTRL_FREQ_LSB           3
`define CTRL_SCS_MSB            1
`define CTRL_SCS_LSB            0
`define FAIL_FLAG_BIT           7
`define FAIL_IRQ_EN_BIT         7
`define STAT_STARTUP_TIMER_BIT  5

`define FREQ_SELECT_RESET       4'h7
`define SCS_RESET               2'h0
`define SCS_CONFIG_SOURCE       2'h0
`define SCS_SECONDARY           2'h1
`define FREQ_LF_PREFIX          3'h0

`define MODE_LOW_POWER_CRYSTAL  3'h0
`define MODE_STANDARD_CRYSTAL   3'h1
`define MODE_HIGH_SPEED_CRYSTAL 3'h2
`define MODE_INTERNAL_OSC       3'h4

`define STARTUP_TIMER_CYCLES    1024
`define SHORT_DELAY_CYCLES      2
`define LF_SWITCH_CYCLES        1
`define SAMPLE_DIVIDE           64

`endif

// ### clock_supervisor_pkg.sv
// Types shared by the clock supervisor.
package clock_supervisor_pkg;

   typedef enum logic [5:0] {
      ST_IDLE     = 6'b000001,
      ST_COUNT    = 6'b000010,
      ST_INT_EDGE = 6'b000100,
      ST_HOLD     = 6'b001000,
      ST_RUN      = 6'b010000,
      ST_FAILED   = 6'b100000
   } supervisor_state_type;

   typedef enum logic [1:0] {
      SRC_INTERNAL  = 2'b00,
      SRC_EXTERNAL  = 2'b01,
      SRC_SECONDARY = 2'b10
   } clock_source_type;

endpackage

// ### clock_supervisor.sv
// Two-speed start-up sequencer and fail-safe clock monitor with its APB registers.
//
// Operation
// - Two-speed start-up needs switchover bit, select 00 and a crystal mode.
// - Start-up sequence runs after power-on (after power-up delay) and every wake-up.
// - Fail-safe monitor enable also turns on two-speed start-up.
// - Two-cycle delay for internal, external clock or RC; one cycle switching to LF.
// - During start-up code runs from the internal oscillator at the selected frequency.
// - Start-up timer counts 1024 crystal or secondary clock cycles before switching.
// - After timeout wait internal falling edge, set status, hold low, then switch.
// - Status bit 5 reads 1 on the configured source, 0 on internal.
// - Fail-safe monitor enabled by config, covers external modes, active after timer.
// - Sample clock is the low-frequency oscillator divided by 64.
// - Latch set by external falling edge, cleared by sample rising; empty half fails.
// - On failure switch to internal clock, set fail flag, stay until software reselects.
// - Fail flag with its enable raises an interrupt request.
// - Fail-safe condition clears on reset, sleep or a change of clock select.
// - Clock select change restarts the timer; failure clears after a good switch.
// - Software clears the flag before switching back; hardware sets it again.
// - External clock and RC modes skip the timer; monitor active right after start.
// - Soft PLL enable bit 7 drives the PLL unless the config PLL bit forces it.
// - Four-bit frequency select resets to 0111.
// - Clock select: 1x internal, 01 secondary, 00 configured source.
// - Status reports ready bits; secondary ready reads 1 when it is disabled.
// - Locked and stable bits follow the high-frequency oscillator accuracy.
//
// Chosen here: the APB register port and the register offsets.
`include "clock_supervisor_map.svh"

module clock_supervisor
   import clock_supervisor_pkg::*;
#(
   parameter int STARTUP_CYCLES = `STARTUP_TIMER_CYCLES,
   parameter int SAMPLE_DIVIDE  = `SAMPLE_DIVIDE
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        startup_request,
   input  wire logic        sleep_enter,
   input  wire logic        internal_external_switchover_enable,
   input  wire logic        fail_safe_monitor_enable,
   input  wire logic [2:0]  oscillator_mode_config,
   input  wire logic        config_pll_enable,
   input  wire logic        ext_clk_level,
   input  wire logic        int_clk_level,
   input  wire logic        secondary_clk_level,
   input  wire logic        low_freq_internal_osc_level,
   input  wire logic        secondary_osc_enable,
   input  wire logic        secondary_osc_running,
   input  wire logic        pll_lock,
   input  wire logic        hf_osc_running,
   input  wire logic        hf_within_2pct,
   input  wire logic        hf_within_half_pct,
   input  wire logic        mf_osc_running,
   input  wire logic        lf_osc_running,
   output logic      [1:0]  sys_clk_source,
   output logic             sys_clk_hold,
   output logic      [3:0]  internal_freq_select,
   output logic             pll_enable,
   output logic             osc_fail_irq
);

   localparam int CW = $clog2(STARTUP_CYCLES + 1);
   localparam int DW = $clog2(SAMPLE_DIVIDE);

   // The divider keeps a half count of at least one bit, so the divide must be even and at least 4.
   if (STARTUP_CYCLES < `SHORT_DELAY_CYCLES) begin : g_bad_startup
      $error("clock_supervisor: STARTUP_CYCLES below the short delay");
   end
   if (SAMPLE_DIVIDE < 4 || SAMPLE_DIVIDE % 2 != 0) begin : g_bad_divide
      $error("clock_supervisor: SAMPLE_DIVIDE must be even and at least 4");
   end

   supervisor_state_type state_q;
   supervisor_state_type state_d;
   clock_source_type     src_q;
   clock_source_type     src_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic [DW-2:0] div_q;
   logic          sample_q;
   logic          latch_q;
   logic          soft_pll_q;
   logic [3:0]    freq_q;
   logic [1:0]    scs_q;
   logic          fail_flag_q;
   logic          irq_en_q;
   logic          startup_timer_status_q;
   logic          startup_timer_status_d;
   logic          hold_q;
   logic [7:0]    status_q;
   logic [31:0]   prdata_q;
   logic          pready_q;
   logic          pslverr_q;
   logic          irq_q;
   logic          pll_q;

   // Edges of the sampled clock levels. Each detector resets to the level that cannot
   // fake the edge it reports, so no false edge follows the release of reset.
   logic ext_fall;
   logic int_fall;
   logic sec_fall;
   logic lf_rise;

   level_edge #(
      .RESET_LEVEL(1'b0)
   ) ext_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (ext_clk_level),
      .rise    (),
      .fall    (ext_fall)
   );

   level_edge #(
      .RESET_LEVEL(1'b0)
   ) int_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (int_clk_level),
      .rise    (),
      .fall    (int_fall)
   );

   level_edge #(
      .RESET_LEVEL(1'b0)
   ) sec_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (secondary_clk_level),
      .rise    (),
      .fall    (sec_fall)
   );

   level_edge #(
      .RESET_LEVEL(1'b1)
   ) lf_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (low_freq_internal_osc_level),
      .rise    (lf_rise),
      .fall    ()
   );

   // APB decode; the first access cycle is a wait state so read data comes from a flop.
   wire apb_access = psel & penable & ~pready_q;
   wire apb_fire   = psel & penable & pready_q;
   wire sel_ctrl   = paddr == `OSC_CONTROL_OFFSET;
   wire sel_stat   = paddr == `OSC_STATUS_OFFSET;
   wire sel_flag   = paddr == `OSC_FAIL_FLAG_OFFSET;
   wire sel_ien    = paddr == `OSC_FAIL_IRQ_EN_OFFSET;
   wire mapped     = sel_ctrl | sel_stat | sel_flag | sel_ien;
   wire wr_ctrl    = apb_fire & pwrite & sel_ctrl;
   wire wr_flag    = apb_fire & pwrite & sel_flag;
   wire wr_ien     = apb_fire & pwrite & sel_ien;
   wire [1:0] new_scs = pwdata[`CTRL_SCS_MSB:`CTRL_SCS_LSB];
   wire scs_change = wr_ctrl & (new_scs != scs_q);

   wire [7:0] ctrl_rd = {soft_pll_q, freq_q, 1'b0, scs_q};
   wire [7:0] rd_byte = sel_ctrl ? ctrl_rd :
                        sel_stat ? status_q :
                        sel_flag ? {fail_flag_q, 7'h00} :
                        sel_ien  ? {irq_en_q, 7'h00} : 8'h00;

   wire mode_crystal = oscillator_mode_config == `MODE_LOW_POWER_CRYSTAL ||
                       oscillator_mode_config == `MODE_STANDARD_CRYSTAL ||
                       oscillator_mode_config == `MODE_HIGH_SPEED_CRYSTAL;
   wire mode_int    = oscillator_mode_config == `MODE_INTERNAL_OSC;
   wire target_sec  = scs_q == `SCS_SECONDARY;
   wire target_ext  = (scs_q == `SCS_CONFIG_SOURCE) & ~mode_int;
   wire target_int  = ~target_sec & ~target_ext;
   wire lf_selected = freq_q[3:1] == `FREQ_LF_PREFIX;
   // Two-speed conditions; monitor enable forces it.
   wire two_speed   = (internal_external_switchover_enable | fail_safe_monitor_enable) &
                      (scs_q == `SCS_CONFIG_SOURCE) & mode_crystal;
   // Crystal and secondary need the full timer; others do not.
   wire needs_timer = (target_ext & mode_crystal) | target_sec;
   wire [CW-1:0] delay_len = needs_timer ? CW'(STARTUP_CYCLES) :
                             (target_int & lf_selected) ? CW'(`LF_SWITCH_CYCLES) :
                             CW'(`SHORT_DELAY_CYCLES);
   wire target_fall = target_sec ? sec_fall : target_ext ? ext_fall : int_fall;
   wire delay_done  = target_fall & (cnt_q == delay_len - CW'(1));

   // Sample clock edges from the divided low-frequency oscillator.
   wire div_wrap    = lf_rise & (div_q == (DW-1)'(SAMPLE_DIVIDE / 2 - 1));
   wire sample_rise = div_wrap & ~sample_q;
   wire sample_fall = div_wrap & sample_q;
   wire mon_fall    = (src_q == SRC_SECONDARY) ? sec_fall : ext_fall;
   // Monitor only after the start-up timer, on an external source.
   wire monitoring  = fail_safe_monitor_enable & (state_q == ST_RUN) & (src_q != SRC_INTERNAL);
   // A whole sample half-cycle without an external low edge.
   wire fail_evt    = monitoring & sample_fall & ~latch_q & ~mon_fall;

   always_comb begin
      state_d = state_q;
      src_d   = src_q;
      cnt_d   = cnt_q;
      startup_timer_status_d  = startup_timer_status_q;
      unique case (state_q)
         ST_IDLE: begin
            // Start on power-up release or wake-up.
            if (startup_request) begin
               state_d = ST_COUNT;
               cnt_d   = '0;
            end
         end
         ST_COUNT: begin
            // Execution stays on the internal oscillator while counting.
            src_d = SRC_INTERNAL;
            if (target_fall) begin
               cnt_d = cnt_q + CW'(1);
            end
            if (delay_done) begin
               state_d = target_int ? ST_RUN : ST_INT_EDGE;
            end
         end
         ST_INT_EDGE: begin
            // Wait internal falling edge, then load the status bit: 1 for the configured source, 0 for secondary.
            if (int_fall) begin
               state_d = ST_HOLD;
               startup_timer_status_d  = target_ext;
            end
         end
         ST_HOLD: begin
            // Clock held low until the new clock falls.
            if (target_fall) begin
               state_d = ST_RUN;
               src_d   = target_sec ? SRC_SECONDARY : SRC_EXTERNAL;
            end
         end
         ST_RUN: begin
            // Fall back to the internal source on failure.
            if (fail_evt) begin
               state_d = ST_FAILED;
               src_d   = SRC_INTERNAL;
               startup_timer_status_d  = 1'b0;
            end
         end
         ST_FAILED: begin
            src_d = SRC_INTERNAL;
         end
      endcase
      // A new select restarts the timer from the internal oscillator.
      if (scs_change) begin
         state_d = ST_COUNT;
         src_d   = SRC_INTERNAL;
         cnt_d   = '0;
         startup_timer_status_d  = 1'b0;
      end
      // Sleep aborts start-up and clears the fail-safe condition.
      if (sleep_enter) begin
         state_d = ST_IDLE;
         src_d   = SRC_INTERNAL;
         startup_timer_status_d  = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         src_q   <= SRC_INTERNAL;
         cnt_q   <= '0;
         startup_timer_status_q  <= 1'b0;
         hold_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         src_q   <= src_d;
         cnt_q   <= cnt_d;
         startup_timer_status_q  <= startup_timer_status_d;
         // Without two-speed start-up the clock stays stopped through the crystal timer and the
         // internal-edge wait, so no code runs on the internal oscillator in that mode.
         hold_q  <= (state_d == ST_HOLD) |
                    (((state_d == ST_COUNT) | (state_d == ST_INT_EDGE)) & needs_timer & ~two_speed & target_ext);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q      <= '0;
         sample_q   <= 1'b0;
         latch_q    <= 1'b0;
      end else begin
         if (lf_rise) begin
            div_q <= div_wrap ? '0 : div_q + (DW-1)'(1);
         end
         if (div_wrap) begin
            sample_q <= ~sample_q;
         end
         // Latch: set wins over the sample-rise clear.
         if (mon_fall) begin
            latch_q <= 1'b1;
         end else if (sample_rise) begin
            latch_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_pll_q  <= 1'b0;
         freq_q      <= `FREQ_SELECT_RESET;
         scs_q       <= `SCS_RESET;
         fail_flag_q <= 1'b0;
         irq_en_q    <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            soft_pll_q <= pwdata[`CTRL_SOFT_PLL_BIT];
            freq_q     <= pwdata[`CTRL_FREQ_MSB:`CTRL_FREQ_LSB];
            scs_q      <= new_scs;
         end
         // Hardware set wins over the software write-one clear.
         if (fail_evt) begin
            fail_flag_q <= 1'b1;
         end else if (wr_flag && pwdata[`FAIL_FLAG_BIT]) begin
            fail_flag_q <= 1'b0;
         end
         if (wr_ien) begin
            irq_en_q <= pwdata[`FAIL_IRQ_EN_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q  <= 8'h00;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q     <= 1'b0;
         pll_q     <= 1'b0;
      end else begin
         // Status is built only by hardware; never written.
         status_q  <= {~secondary_osc_enable | secondary_osc_running, pll_lock, startup_timer_status_d,
                       hf_osc_running, hf_within_2pct, mf_osc_running, lf_osc_running,
                       hf_within_half_pct};
         pready_q  <= apb_access;
         pslverr_q <= apb_access & ~mapped;
         if (apb_access) begin
            prdata_q <= {24'h00_0000, rd_byte};
         end
         // Interrupt request from flag and enable.
         irq_q     <= fail_flag_q & irq_en_q;
         // Config bit forces the PLL on.
         pll_q     <= config_pll_enable | soft_pll_q;
      end
   end

   assign prdata               = prdata_q;
   assign pready               = pready_q;
   assign pslverr              = pslverr_q;
   assign sys_clk_source       = src_q;
   assign sys_clk_hold         = hold_q;
   assign internal_freq_select = freq_q;
   assign pll_enable           = pll_q;
   assign osc_fail_irq         = irq_q;

endmodule // clock_supervisor

// Edge detector for one clock level sampled on pclk.
module level_edge
   import clock_supervisor_pkg::*;
#(
   parameter bit RESET_LEVEL = 1'b0
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic level,
   output logic      rise,
   output logic      fall
);

   logic prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= RESET_LEVEL;
      end else begin
         prev_q <= level;
      end
   end

   assign rise = ~prev_q & level;
   assign fall = prev_q & ~level;

endmodule // level_edge

// ### osc_source.sv
// Behavioural oscillator standing in for a clock source outside the supervisor.
module osc_source #(
   parameter int HALF = 2
) (
   input  wire logic pclk,
   input  wire logic run,
   output logic      clk_level
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt_q = 0;
   initial clk_level = 1'b1;
   // A failed source just stops, so its level freezes as a dead crystal output would.
   always @(posedge pclk) begin
      if (run) begin
         cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
         if (cnt_q == HALF - 1) begin
            clk_level <= ~clk_level;
         end
      end
   end
endmodule // osc_source

// ### clock_supervisor_assertions.sv
// Concurrent checks on the clock supervisor ports.
module clock_supervisor_assertions #(
   parameter int STARTUP_CYCLES = 1024,
   parameter int SAMPLE_DIVIDE  = 64
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        startup_request,
   input wire logic        sleep_enter,
   input wire logic        internal_external_switchover_enable,
   input wire logic        fail_safe_monitor_enable,
   input wire logic [2:0]  oscillator_mode_config,
   input wire logic        config_pll_enable,
   input wire logic        ext_clk_level,
   input wire logic        low_freq_internal_osc_level,
   input wire logic [1:0]  sys_clk_source,
   input wire logic        sys_clk_hold,
   input wire logic [3:0]  internal_freq_select,
   input wire logic        pll_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [15:0] falls_q;
   logic [15:0] lf_q;
   logic        two_speed;
   logic        wr_ctrl;
   logic        xtal;
   logic [1:0]  scs_t;
   logic        ext_tgt;
   int          need;
   assign two_speed = internal_external_switchover_enable | fail_safe_monitor_enable;
   assign wr_ctrl = psel & penable & pready & pwrite & (paddr == 12'h000);
   assign xtal = oscillator_mode_config < 3'h3;
   assign need = xtal ? STARTUP_CYCLES : 2;
   assign ext_tgt = scs_t == 2'b00;
   // Falls seen since the count last restarted; lf rises since the monitored clock last fell;
   // the clock select last written, since only the configured source is counted on ext_clk_level.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         falls_q <= '0;
         lf_q <= '0;
         scs_t <= '0;
      end else begin
         if (wr_ctrl) scs_t <= pwdata[1:0];
         if (startup_request | sleep_enter | wr_ctrl) falls_q <= '0;
         else if ($fell(ext_clk_level)) falls_q <= falls_q + 16'h1;
         if ($fell(ext_clk_level) || sys_clk_source != 2'b01 || !fail_safe_monitor_enable) lf_q <= '0;
         else if ($rose(low_freq_internal_osc_level)) lf_q <= lf_q + 16'h1;
      end
   end
   property p_freq_reset;
      $rose(presetn) |-> internal_freq_select == 4'h7;
   endproperty
   property p_pll;
      config_pll_enable |=> pll_enable;
   endproperty
   property p_two_speed;
      startup_request && xtal && two_speed && sys_clk_source == 2'b00 && !sys_clk_hold
         |=> (!sys_clk_hold && sys_clk_source == 2'b00) [*8];
   endproperty
   property p_no_two_speed;
      startup_request && xtal && !two_speed && sys_clk_source == 2'b00 && !sys_clk_hold |-> ##[1:3] sys_clk_hold;
   endproperty
   property p_count;
      $rose(sys_clk_hold) && (two_speed || !xtal) && ext_tgt |-> int'(falls_q) >= need && int'(falls_q) <= need + 4;
   endproperty
   property p_switch;
      $changed(sys_clk_source) && sys_clk_source != 2'b00 |-> $past(sys_clk_hold);
   endproperty
   property p_hold_ends;
      sys_clk_hold && two_speed && ext_tgt && $fell(ext_clk_level) |-> ##[1:3] !sys_clk_hold;
   endproperty
   property p_detect;
      sys_clk_source == 2'b01 && fail_safe_monitor_enable |-> int'(lf_q) <= 2 * SAMPLE_DIVIDE;
   endproperty
   property p_fail_stays;
      $past(sys_clk_source) == 2'b01 && sys_clk_source == 2'b00 && !$past(wr_ctrl) && !$past(sleep_enter)
         |-> sys_clk_source == 2'b00 [*4];
   endproperty
   a_freq_reset: assert property (p_freq_reset) else $error("frequency select not at reset value");
   a_pll: assert property (p_pll) else $error("pll not forced on by config bit");
   a_two_speed: assert property (p_two_speed) else $error("internal clock not kept during count");
   a_no_two_speed: assert property (p_no_two_speed) else $error("clock not held during crystal count");
   a_count: assert property (p_count) else $error("wrong number of start-up falls");
   a_switch: assert property (p_switch) else $error("source switched without holding low");
   a_hold_ends: assert property (p_hold_ends) else $error("hold not released at clock fall");
   a_detect: assert property (p_detect) else $error("stopped clock not detected in time");
   a_fail_stays: assert property (p_fail_stays) else $error("fallback source not kept");
   c_hold: cover property ($rose(sys_clk_hold));
   c_fallback: cover property ($past(sys_clk_source) == 2'b01 && sys_clk_source == 2'b00);
   c_write: cover property (wr_ctrl);
endmodule // clock_supervisor_assertions

bind clock_supervisor clock_supervisor_assertions #(
   .STARTUP_CYCLES(STARTUP_CYCLES),
   .SAMPLE_DIVIDE(SAMPLE_DIVIDE)
) checker_i (.*);

// ### two_speed_startup_fail_safe_clock_tb.sv
// Bench for the clock supervisor: register access, start-up in several modes, fail-safe fallback.
module two_speed_startup_fail_safe_clock_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, startup_request, sleep_enter, pready, pslverr;
   logic        sw_en, fcm_en, config_pll, run_ext, ext_lvl, int_lvl, lf_lvl, hold, pll_en, irq, err;
   logic        osc_on, sec_lvl;
   logic [2:0]  mode;
   logic [7:0]  st_in;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  src;
   logic [3:0]  freq;
   logic [12:0] cfg [4];
   int          num_errors, n_checks;
   clock_supervisor #(.STARTUP_CYCLES(8), .SAMPLE_DIVIDE(8)) dut (
      .*,
      .internal_external_switchover_enable(sw_en), .fail_safe_monitor_enable(fcm_en),
      .oscillator_mode_config(mode), .config_pll_enable(config_pll), .ext_clk_level(ext_lvl),
      .int_clk_level(int_lvl), .secondary_clk_level(sec_lvl), .low_freq_internal_osc_level(lf_lvl),
      .secondary_osc_enable(st_in[7]), .secondary_osc_running(st_in[6]), .pll_lock(st_in[5]),
      .hf_osc_running(st_in[4]), .hf_within_2pct(st_in[3]), .mf_osc_running(st_in[2]),
      .lf_osc_running(st_in[1]), .hf_within_half_pct(st_in[0]), .sys_clk_source(src),
      .sys_clk_hold(hold), .internal_freq_select(freq), .pll_enable(pll_en), .osc_fail_irq(irq));
   osc_source ext_osc (.pclk(pclk), .run(run_ext), .clk_level(ext_lvl));
   osc_source sec_osc (.pclk(pclk), .run(osc_on), .clk_level(sec_lvl));
   osc_source #(.HALF(1)) int_osc (.pclk(pclk), .run(osc_on), .clk_level(int_lvl));
   osc_source #(.HALF(4)) lf_osc (.pclk(pclk), .run(osc_on), .clk_level(lf_lvl));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) num_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdchk(input string what, input logic [11:0] a, input logic [7:0] e, input logic e_err);
      apb(1'b0, a, 8'h00);
      chk(what, rd, {24'h0, e});
      chk("pslverr", {31'h0, err}, {31'h0, e_err});
   endtask
   task automatic wait_src(input logic [1:0] s);
      int n;
      n = 0;
      while (src !== s && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      chk("sys_clk_source", {30'h0, src}, {30'h0, s});
   endtask
   task automatic do_reset;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   task automatic start_pulse;
      startup_request <= 1'b1;
      @(posedge pclk);
      startup_request <= 1'b0;
   endtask
   // Secondary ready reads 1 whenever that oscillator is disabled.
   function automatic logic [7:0] stat(input logic b5);
      return {~st_in[7] | st_in[6], st_in[5], b5, st_in[4:0]};
   endfunction
   task automatic close_out;
      $display("Checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      #2000000;
      num_errors++;
      close_out;
   end
   initial begin
      cfg = '{{3'h0, 2'b11, 8'h3f}, {3'h5, 2'b01, 8'h80}, {3'h1, 2'b00, 8'hd5}, {3'h2, 2'b01, 8'h6a}};
      {presetn, psel, penable, pwrite, startup_request, sleep_enter, config_pll} = '0;
      {sw_en, fcm_en, mode, st_in, paddr, pwdata} = '0;
      run_ext = 1'b1;
      osc_on = 1'b1;
      num_errors = 0;
      n_checks = 0;
      @(posedge pclk);
      foreach (cfg[i]) begin
         {mode, sw_en, fcm_en, st_in} <= cfg[i];
         do_reset;
         rdchk("control", 12'h000, 8'h38, 1'b0);
         start_pulse;
         wait_src(2'b01);
         rdchk("status", 12'h004, stat(1'b1), 1'b0);
      end
      rdchk("unmapped", 12'h010, 8'h00, 1'b1);
      apb(1'b1, 12'h004, 8'hff);
      rdchk("status", 12'h004, stat(1'b1), 1'b0);
      run_ext <= 1'b0;
      wait_src(2'b00);
      rdchk("fail flag", 12'h008, 8'h80, 1'b0);
      rdchk("status", 12'h004, stat(1'b0), 1'b0);
      chk("freq", {28'h0, freq}, 32'h7);
      apb(1'b1, 12'h00c, 8'h80);
      @(posedge pclk);
      chk("irq", {31'h0, irq}, 32'h1);
      apb(1'b1, 12'h008, 8'h80);
      @(posedge pclk);
      chk("irq", {31'h0, irq}, 32'h0);
      run_ext <= 1'b1;
      apb(1'b1, 12'h000, 8'h0a);
      apb(1'b1, 12'h000, 8'h38);
      wait_src(2'b01);
      rdchk("fail flag", 12'h008, 8'h00, 1'b0);
      sleep_enter <= 1'b1;
      @(posedge pclk);
      sleep_enter <= 1'b0;
      rdchk("status", 12'h004, stat(1'b0), 1'b0);
      start_pulse;
      wait_src(2'b01);
      apb(1'b1, 12'h000, 8'hfc);
      rdchk("control", 12'h000, 8'hf8, 1'b0);
      chk("pll", {31'h0, pll_en}, 32'h1);
      chk("freq", {28'h0, freq}, 32'hf);
      apb(1'b1, 12'h000, 8'h78);
      @(posedge pclk);
      chk("pll", {31'h0, pll_en}, 32'h0);
      config_pll <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("pll", {31'h0, pll_en}, 32'h1);
      apb(1'b1, 12'h000, 8'h79);
      wait_src(2'b10);
      rdchk("status", 12'h004, stat(1'b0), 1'b0);
      close_out;
   end
endmodule // two_speed_startup_fail_safe_clock_tb
